/* File: rtl/mmd_decoder.sv */
// Top of the memory map decoder: relocation lock, selects, fetch checks and vectors.
`timescale 1ns/1ps
module mmd_decoder (
	input  wire  logic              clock,
	input  wire  logic              sys_rst,
	input  wire  mmd_pkg::mmd_req_t req,
	input  wire  logic              reloc_valid,
	input  wire  logic [3:0]        reloc_setting,
	input  wire  logic              exp_mode,
	input  wire  logic              sreg_mapped,
	input  wire  logic [15:0]       read_data,
	input  wire  logic              vec_load,
	input  wire  logic              tcall_load,
	input  wire  logic [4:0]        tcall_index,
	input  wire  logic [10:0]       fcall_offset,
	input  wire  logic              fcall_load,
	output mmd_pkg::mmd_sel_t       sel_ff,
	output mmd_pkg::mmd_attr_t      attr_ff,
	output logic [19:0]             phys_addr_ff,
	output logic                    fetch_fault_ff,
	output logic                    deadlock_ff,
	output logic                    reloc_locked_ff,
	output logic                    reloc_high_ff,
	output logic [19:0]             branch_target_ff,
	output logic [2:0]              bank_num_ff,
	output logic                    peripheral_ram_fetch_ready_ff,
	output logic [19:0]             table_addr_ff
);
	import mmd_pkg::*;

	// ==========================================================================
	// Relocation lock and deadlock state
	// ==========================================================================
	mmd_state_t  state_ff;
	mmd_state_t  nxt_state;
	logic        nxt_reloc_high;
	logic        nxt_reloc_locked;

	mmd_sel_t    comb_sel;
	mmd_attr_t   comb_attr;

	mmd_region u_region (
		.addr       (req.addr),
		.reloc_high (reloc_high_ff),
		.exp_mode   (exp_mode),
		.sel        (comb_sel),
		.attr       (comb_attr)
	);

	// The first relocation request after reset is taken unless already in MMD_DEADLOCK; later ones are ignored.
	always_comb begin
		nxt_state        = state_ff;
		nxt_reloc_high   = reloc_high_ff;
		nxt_reloc_locked = reloc_locked_ff;
		case (state_ff)
			MMD_WAIT_RELOC: begin
				if (reloc_valid) begin
					nxt_reloc_high   = (reloc_setting == RELOC_HIGH);
					nxt_reloc_locked = 1'b1;
					nxt_state        = MMD_LOCKED;
				end
			end
			MMD_LOCKED: begin
				nxt_state = MMD_LOCKED;
			end
			default: begin
				nxt_state = MMD_DEADLOCK;
			end
		endcase
		// An unmapped register access freezes the bus side until reset.
		if (req.valid && comb_sel.sreg && !sreg_mapped) begin
			nxt_state = MMD_DEADLOCK;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_ff        <= MMD_WAIT_RELOC;
			reloc_high_ff   <= 1'b0;
			reloc_locked_ff <= 1'b0;
		end else begin
			state_ff        <= nxt_state;
			reloc_high_ff   <= nxt_reloc_high;
			reloc_locked_ff <= nxt_reloc_locked;
		end
	end

	// ==========================================================================
	// Registered selects and access checks
	// ==========================================================================
	mmd_sel_t    nxt_sel;
	mmd_attr_t   nxt_attr;
	logic [19:0] nxt_phys;
	logic        nxt_fault;
	logic        nxt_deadlock;
	logic        live;

	// Selects are registered so every output leaves a flip-flop; a stuck state
	// drops them all so no region sees further traffic.
	always_comb begin
		live         = req.valid && (state_ff != MMD_DEADLOCK);
		nxt_sel      = live ? comb_sel : '0;
		nxt_attr     = live ? comb_attr : '0;
		nxt_phys     = req.addr;
		nxt_deadlock = (nxt_state == MMD_DEADLOCK);
		nxt_fault    = live && req.fetch && (comb_sel.fram || comb_sel.sreg
			|| comb_sel.xwin);
		// Window traffic is handed to the external bus as an ordinary cycle.
		if (comb_sel.xwin) begin
			nxt_phys = req.addr;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sel_ff         <= '0;
			attr_ff        <= '0;
			phys_addr_ff   <= 20'h00000;
			fetch_fault_ff <= 1'b0;
			deadlock_ff    <= 1'b0;
		end else begin
			sel_ff         <= nxt_sel;
			attr_ff        <= nxt_attr;
			phys_addr_ff   <= nxt_phys;
			fetch_fault_ff <= nxt_fault;
			deadlock_ff    <= nxt_deadlock;
		end
	end

	// ==========================================================================
	// Peripheral RAM fetch pacing
	// ==========================================================================
	logic [1:0] pcnt_ff;
	logic [1:0] nxt_pcnt;
	logic       nxt_pready;

	// A halfword is ready once every two clocks while fetches target that RAM.
	always_comb begin
		nxt_pcnt   = 2'h0;
		nxt_pready = 1'b0;
		if (live && req.fetch && comb_sel.peripheral_ram) begin
			if (pcnt_ff == PERIPHERAL_RAM_FETCH_CLKS - 2'h1) begin
				nxt_pready = 1'b1;
			end else begin
				nxt_pcnt = pcnt_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pcnt_ff             <= 2'h0;
			peripheral_ram_fetch_ready_ff <= 1'b0;
		end else begin
			pcnt_ff             <= nxt_pcnt;
			peripheral_ram_fetch_ready_ff <= nxt_pready;
		end
	end

	// ==========================================================================
	// Vector, table call and fixed-area call targets
	// ==========================================================================
	logic [19:0] nxt_target;
	logic [2:0]  nxt_bank;
	logic [19:0] nxt_taddr;

	// Table address for a table call: base plus two bytes per entry.
	always_comb begin
		nxt_taddr = TCALL_LO + {14'h0000, tcall_index, 1'b0};
		if (tcall_index > TCALL_MAX_IDX) begin
			nxt_taddr = TCALL_LO;
		end
	end

	// A 16-bit entry always lands in the base area; upper nibble forced to zero.
	always_comb begin
		nxt_target = branch_target_ff;
		nxt_bank   = bank_num_ff;
		if (vec_load) begin
			nxt_target = {4'h0, read_data};
			nxt_bank   = read_data[2:0];
		end else if (tcall_load) begin
			nxt_target = {4'h0, read_data};
		end else if (fcall_load) begin
			nxt_target = FCALL_LO | {9'h000, fcall_offset};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			branch_target_ff <= VEC_RESET;
			bank_num_ff      <= 3'h0;
			table_addr_ff    <= TCALL_LO;
		end else begin
			branch_target_ff <= nxt_target;
			bank_num_ff      <= nxt_bank;
			table_addr_ff    <= nxt_taddr;
		end
	end

endmodule : mmd_decoder

/* File: rtl/mmd_pkg.sv */
// Package with the memory map constants and carrier types of the address decoder.
package mmd_pkg;

	// ==========================================================================
	// Address map
	// ==========================================================================
	localparam int unsigned ADDR_W          = 20;
	localparam logic [19:0] VEC_LO          = 20'h00000;
	localparam logic [19:0] VEC_HI          = 20'h0003F;
	localparam logic [19:0] VEC_RESET       = 20'h00000;
	localparam logic [19:0] VEC_NMI         = 20'h00002;
	localparam logic [19:0] VEC_WATCHDOG    = 20'h00004;
	localparam logic [19:0] VEC_OPERAND_ERR = 20'h0003C;
	localparam logic [19:0] VEC_BREAK_TRAP  = 20'h0003E;
	localparam logic [19:0] TCALL_LO        = 20'h00040;
	localparam logic [19:0] TCALL_HI        = 20'h0007F;
	localparam logic [4:0]  TCALL_MAX_IDX   = 5'h1F;
	localparam logic [19:0] FCALL_LO        = 20'h00800;
	localparam logic [19:0] FCALL_HI        = 20'h00FFF;
	localparam logic [19:0] BASE_HI         = 20'h0FFFF;
	localparam logic [19:0] RELOC_OFFSET    = 20'hF0000;
	localparam logic [3:0]  RELOC_LOW       = 4'h0;
	localparam logic [3:0]  RELOC_HIGH      = 4'hF;

	// Low 16 bits of each internal data boundary, before relocation.
	localparam logic [15:0] PERIPHERAL_RAM_LO_DEF     = 16'hD600;
	localparam logic [15:0] FRAM_LO         = 16'hFD00;
	localparam logic [15:0] FRAM_HI         = 16'hFEFF;
	localparam logic [15:0] SHORT_LO        = 16'hFD20;
	localparam logic [15:0] BANK_LO         = 16'hFE80;
	localparam logic [15:0] SVC_LO          = 16'hFE06;
	localparam logic [15:0] SVC_HI          = 16'hFE39;
	localparam logic [15:0] SVC_GAP0        = 16'hFE22;
	localparam logic [15:0] SVC_GAP1        = 16'hFE2A;
	localparam logic [15:0] SVC_GAP2        = 16'hFE30;
	localparam logic [15:0] SREG_LO         = 16'hFF00;
	localparam logic [15:0] XWIN_LO         = 16'hFFD0;
	localparam logic [15:0] XWIN_HI         = 16'hFFDF;

	// ROM top at the largest fitted capacity; beyond it lies external memory.
	localparam logic [19:0] ROM_HI_DEF      = 20'h3FFFF;

	// Peripheral RAM fetch delivers one halfword every two clocks.
	localparam logic [1:0]  PERIPHERAL_RAM_FETCH_CLKS = 2'h2;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [1:0] {
		MMD_WAIT_RELOC = 2'b00,
		MMD_LOCKED     = 2'b01,
		MMD_DEADLOCK   = 2'b11
	} mmd_state_t;

	typedef struct packed {
		logic vec_rom;
		logic peripheral_ram;
		logic fram;
		logic sreg;
		logic xwin;
		logic ext;
	} mmd_sel_t;

	typedef struct packed {
		logic vector;
		logic tcall_table;
		logic fcall_area;
		logic base;
		logic short_dir;
		logic bank_regs;
		logic svc_word;
	} mmd_attr_t;

	typedef struct packed {
		logic        valid;
		logic        fetch;
		logic        write;
		logic [19:0] addr;
	} mmd_req_t;

endpackage : mmd_pkg

/* File: rtl/mmd_region.sv */
// Combinational region classifier of the address decoder.
`timescale 1ns/1ps
module mmd_region (
	input  wire  logic [19:0]      addr,
	input  wire  logic             reloc_high,
	input  wire  logic             exp_mode,
	output mmd_pkg::mmd_sel_t      sel,
	output mmd_pkg::mmd_attr_t     attr
);
	import mmd_pkg::*;

	logic [19:0] data_base;
	logic [15:0] low;
	logic        in_page;
	logic        in_data;

	// ==========================================================================
	// Internal data area placement
	// ==========================================================================
	// The data area sits in page 0 or, relocated, in page F of the upper nibble.
	always_comb begin
		data_base = reloc_high ? RELOC_OFFSET : 20'h00000;
		low       = addr[15:0];
		in_page   = (addr[19:16] == data_base[19:16]);
		in_data   = in_page && (low >= PERIPHERAL_RAM_LO_DEF);
	end

	// ==========================================================================
	// Region selects
	// ==========================================================================
	// Exactly one select is raised; data area checks come first so it wins overlaps.
	always_comb begin
		sel = '0;
		if (in_data && low >= SREG_LO) begin
			if (exp_mode && low >= XWIN_LO && low <= XWIN_HI) begin
				sel.xwin = 1'b1;
			end else begin
				sel.sreg = 1'b1;
			end
		end else if (in_data && low >= FRAM_LO) begin
			sel.fram = 1'b1;
		end else if (in_data) begin
			sel.peripheral_ram = 1'b1;
		end else if (addr <= ROM_HI_DEF) begin
			sel.vec_rom = 1'b1;
		end else begin
			sel.ext = 1'b1;
		end
	end

	// ==========================================================================
	// Attributes of the address within special areas
	// ==========================================================================
	// Attributes only inform; none of them blocks an ordinary access.
	always_comb begin
		attr             = '0;
		attr.vector      = (addr <= VEC_HI);
		attr.tcall_table = (addr >= TCALL_LO) && (addr <= TCALL_HI);
		attr.fcall_area  = (addr >= FCALL_LO) && (addr <= FCALL_HI);
		attr.base        = (addr <= BASE_HI);
		attr.short_dir   = sel.fram && (low >= SHORT_LO);
		attr.bank_regs   = sel.fram && (low >= BANK_LO);
		attr.svc_word    = sel.fram && (low >= SVC_LO) && (low <= SVC_HI)
			&& (low[15:1] != SVC_GAP0[15:1])
			&& (low[15:1] != SVC_GAP1[15:1])
			&& (low[15:1] != SVC_GAP2[15:1]);
	end

endmodule : mmd_region

/* File: testbench/mmd_decoder_chk.sv */
// Concurrent checks on the ports of the memory map decoder.
`timescale 1ns/1ps
module mmd_decoder_chk (
	input wire logic              clock,
	input wire logic              sys_rst,
	input wire mmd_pkg::mmd_req_t req,
	input wire logic              reloc_valid,
	input wire logic [3:0]        reloc_setting,
	input wire logic              exp_mode,
	input wire logic              sreg_mapped,
	input wire logic [15:0]       read_data,
	input wire logic              vec_load,
	input wire logic              tcall_load,
	input wire logic [4:0]        tcall_index,
	input wire mmd_pkg::mmd_sel_t sel_ff,
	input wire logic              fetch_fault_ff,
	input wire logic              deadlock_ff,
	input wire logic              reloc_locked_ff,
	input wire logic              reloc_high_ff,
	input wire logic [19:0]       branch_target_ff,
	input wire logic [2:0]        bank_num_ff,
	input wire logic [19:0]       table_addr_ff
);
	import mmd_pkg::*;
	// =========
	// Helpers
	// =========
	// Area checks only cover the low placement; the bench judges the high one.
	logic low_req;
	assign low_req = req.valid && !deadlock_ff && !reloc_high_ff && req.addr[19:16] == 4'h0;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// =========
	// Assertions
	// =========
	a_sel_one_hot: assert property ($onehot0(sel_ff))
		else $error("Region selects are not one-hot.");
	a_lock_holds: assert property (reloc_locked_ff |=> reloc_locked_ff && $stable(reloc_high_ff))
		else $error("Placement changed after it was locked.");
	a_reloc_taken: assert property (reloc_valid && !reloc_locked_ff && !deadlock_ff |=>
		reloc_locked_ff && reloc_high_ff == ($past(reloc_setting) == 4'hF))
		else $error("Relocation pulse was not taken correctly.");
	a_vector_rom: assert property (low_req && req.addr[15:6] == 10'h000 |=> sel_ff.vec_rom)
		else $error("Vector area not routed to program memory.");
	a_fram_fetch: assert property (low_req && req.fetch && req.addr[15:0] inside {[16'hFD00:16'hFEFF]}
		|=> sel_ff.fram && fetch_fault_ff)
		else $error("Fetch from fast RAM not flagged.");
	a_sreg_area: assert property (low_req && sreg_mapped && !exp_mode && req.addr[15:8] == 8'hFF
		|=> sel_ff.sreg)
		else $error("Register area not selected.");
	a_xwin_area: assert property (low_req && exp_mode && req.addr[15:4] == 12'hFFD |=> sel_ff.xwin)
		else $error("External register window not selected.");
	a_dead_set: assert property (low_req && !sreg_mapped && !exp_mode && req.addr[15:8] == 8'hFF
		|=> deadlock_ff)
		else $error("Unmapped register access did not lock up.");
	a_dead_sticky: assert property (deadlock_ff |=> deadlock_ff && sel_ff == '0)
		else $error("Lock-up released or selects active.");
	a_vec_bank: assert property (vec_load |=> bank_num_ff == 3'($past(read_data))
		&& branch_target_ff == {4'h0, $past(read_data)})
		else $error("Vector target or bank number wrong.");
	a_table_addr: assert property (tcall_load |=>
		table_addr_ff == 20'h00040 + {14'h0000, $past(tcall_index), 1'b0})
		else $error("Table entry address wrong.");
endmodule : mmd_decoder_chk

bind mmd_decoder mmd_decoder_chk u_chk (.*);

/* File: testbench/mmd_cpu_model.sv */
// Behavioural model of the CPU fetch and data access side.
`timescale 1ns/1ps
module mmd_cpu_model (
	input wire logic         clock,
	output mmd_pkg::mmd_req_t req
);
	import mmd_pkg::*;
	// Bus starts idle.
	initial req = '0;
	// Holds one request per cycle for n cycles, a halfword apart, then releases with a changed
	// address so a stale one never decodes by luck. Fast RAM fetches only when a test asks.
	task automatic issue(input logic fetch, input logic [19:0] addr, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			req <= '{1'b1, fetch, 1'b0, addr + 20'(2 * i)};
		end
		@(posedge clock);
		req <= '{1'b0, 1'b0, 1'b0, ~addr};
	endtask : issue
endmodule : mmd_cpu_model

/* File: testbench/mmd_decoder_bench.sv */
// Self-checking testbench of the memory map decoder.
`timescale 1ns/1ps
module mmd_decoder_bench;
	import mmd_pkg::*;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        reloc_valid = 1'b0;
	logic [3:0]  reloc_setting = 4'h0;
	logic        exp_mode = 1'b0;
	logic        sreg_mapped = 1'b1;
	logic [15:0] read_data = 16'h0000;
	logic        vec_load = 1'b0;
	logic        tcall_load = 1'b0;
	logic [4:0]  tcall_index = 5'h00;
	logic [10:0] fcall_offset = 11'h000;
	logic        fcall_load = 1'b0;
	mmd_req_t    req;
	mmd_sel_t    sel_ff;
	mmd_attr_t   attr_ff;
	logic [19:0] phys_addr_ff, branch_target_ff, table_addr_ff;
	logic        fetch_fault_ff, deadlock_ff, reloc_locked_ff, reloc_high_ff, peripheral_ram_fetch_ready_ff;
	logic [2:0]  bank_num_ff;
	int          num_errors = 0;
	int          tests_run = 0;
	int          ready_cnt = 0;
	// Decode table: address, fetch, expansion mode, {select, attribute}, fault.
	logic [19:0] a_tab [16] = '{20'h0003E, 20'h00050, 20'h00FFF, 20'h0D600, 20'h0FD10, 20'h0FD30,
		20'h0FE06, 20'h0FE22, 20'h0FE80, 20'h0FE00, 20'h0FF10, 20'h0FFD0, 20'h0FFD0, 20'h10000,
		20'h40000, 20'h0D5FE};
	logic [15:0] f_tab = 16'h0048;
	logic [15:0] x_tab = 16'h1000;
	logic [15:0] t_tab = 16'h0040;
	logic [12:0] e_tab [16] = '{13'h1048, 13'h1028, 13'h1018, 13'h0808, 13'h0408, 13'h040C,
		13'h040D, 13'h040C, 13'h040E, 13'h040C, 13'h0208, 13'h0208, 13'h0108, 13'h1000,
		13'h0080, 13'h1008};
	// 200 MHz clock; the ready counter lets bursts be judged afterwards.
	always #2.5 clock = ~clock;
	always @(posedge clock) ready_cnt <= ready_cnt + int'(peripheral_ram_fetch_ready_ff);
	mmd_cpu_model u_cpu (.clock(clock), .req(req));
	mmd_decoder uut (.*);
	// =========
	// Shared tasks
	// =========
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic do_reset;
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		check("table address", table_addr_ff, 20'h00040);
		check("lock state", {18'h0, deadlock_ff, reloc_locked_ff}, 20'h0);
	endtask : do_reset
	task automatic pulse_reloc(input logic [3:0] s);
		@(posedge clock);
		reloc_setting <= s;
		reloc_valid <= 1'b1;
		@(posedge clock);
		reloc_valid <= 1'b0;
		#1;
	endtask : pulse_reloc
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// =========
	// Scenarios
	// =========
	// Every area in the low placement, used before any relocation.
	task automatic t_decode;
		for (int i = 0; i < 16; i++) begin
			@(posedge clock);
			exp_mode <= x_tab[i];
			u_cpu.issue(f_tab[i], a_tab[i], 1);
			#1;
			check("select", {7'h00, sel_ff, attr_ff}, {7'h00, e_tab[i]});
			check("fault", {19'h0, fetch_fault_ff}, {19'h0, t_tab[i]});
			check("address", phys_addr_ff, a_tab[i]);
		end
		$display("done: decode");
	endtask : t_decode
	// High placement, a refused second pulse, overlap with program memory.
	task automatic t_reloc;
		pulse_reloc(4'hF);
		check("placement", {18'h0, reloc_locked_ff, reloc_high_ff}, 20'h3);
		pulse_reloc(4'h0);
		check("relock", {18'h0, reloc_locked_ff, reloc_high_ff}, 20'h3);
		u_cpu.issue(1'b0, 20'hFFF10, 1);
		#1;
		check("high sreg", {14'h0, sel_ff}, 20'h04);
		u_cpu.issue(1'b0, 20'h0FF10, 1);
		#1;
		check("rom under", {14'h0, sel_ff}, 20'h20);
		$display("done: relocation");
		do_reset();
	endtask : t_reloc
	// Vector and fixed-area branch targets, and the table entry address.
	task automatic t_branch;
		@(posedge clock);
		read_data <= 16'hABC5;
		vec_load <= 1'b1;
		@(posedge clock);
		vec_load <= 1'b0;
		tcall_index <= 5'h1F;
		tcall_load <= 1'b1;
		#1;
		check("vector", branch_target_ff, 20'h0ABC5);
		check("bank", {17'h0, bank_num_ff}, 20'h5);
		@(posedge clock);
		tcall_load <= 1'b0;
		fcall_offset <= 11'h7FF;
		fcall_load <= 1'b1;
		#1;
		check("table", table_addr_ff, 20'h0007E);
		@(posedge clock);
		fcall_load <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check("fixed call", branch_target_ff, 20'h00FFF);
		$display("done: branch");
	endtask : t_branch
	// Six back-to-back peripheral RAM fetches give three halfwords.
	task automatic t_peripheral_ram;
		int c0;
		c0 = ready_cnt;
		u_cpu.issue(1'b1, 20'h0D600, 6);
		repeat (3) @(posedge clock);
		#1;
		check("fetch rate", 20'(ready_cnt - c0), 20'h3);
		$display("done: peripheral fetch");
	endtask : t_peripheral_ram
	// Unmapped register access locks up until reset.
	task automatic t_deadlock;
		@(posedge clock);
		sreg_mapped <= 1'b0;
		u_cpu.issue(1'b0, 20'h0FF80, 1);
		#1;
		check("lock-up", {19'h0, deadlock_ff}, 20'h1);
		sreg_mapped <= 1'b1;
		pulse_reloc(4'hF);
		u_cpu.issue(1'b0, 20'h0FD30, 1);
		#1;
		check("blocked", {13'h0, reloc_locked_ff, sel_ff}, 20'h0);
		$display("done: lock-up");
		do_reset();
	endtask : t_deadlock
	// =========
	// Sequence
	// =========
	// Main run, then a watchdog that cuts a hang short.
	initial begin
		do_reset();
		t_decode();
		t_branch();
		t_peripheral_ram();
		t_reloc();
		t_deadlock();
		print_verdict();
	end
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
endmodule : mmd_decoder_bench
